// file: core/lcd_top.sv
// Carrier qualification and wake-up logic of a low-frequency receiver, APB registers.
// Assumes the bit slicer output arrives asynchronously on carrier_in.
//
// Summary of operation
// - Reset loads the sync pattern selection with code 01, six bit times.
// - Sync codes: 00 factory test only, 01/10/11 select 6, 7.5, 9 bit times.
// - Carrier mode sets the found flag after qualification time and count limit.
// - Found flag with its enable raises the wake-up interrupt.
// - Data mode powers the decode chain after continuous carrier for qualification time.
// - Once validated in data mode, the time field is ignored for that frame.
// - Receiver reset clears the four-bit qualification time field.
// - Qualification time is counted in received carrier periods.
// - Code 0000 needs 8 periods in both modes.
// - Codes 0xxx keep data mode at 8; carrier mode rises to 1024 at 0111.
// - Codes 1100 to 1111 need 128, 256, 512, 1024 in both modes.
// - Auto-zero runs every 1 ms, also inside long qualification windows.
// - Each auto-zero lasts 64 us with carrier sensing suspended.
// - Carrier back after auto-zero counts as present throughout; counting continues.
// - Data mode gives no found interrupt unless digital decoding is off.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module lcd_top
  import lcd_pkg::*;
#(
  parameter int AZ_PERIOD = AZ_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  // Detector pin
  input  wire logic        carrier_in,
  // Receiver controls and interrupt
  output logic             decode_chain_on_out,
  output logic [1:0]       sync_select_out,
  output logic             autozero_out,
  output logic             irq_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_QUALIFY, ST_FRAME, ST_HELD} lcd_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0]  sync_sel_reg;
  logic [3:0]  carrier_qualify_time;
  logic        detector_mode_select;
  logic        digital_decode_enable;
  logic        rx_enable_reg;
  logic [11:0] carrier_count_limit;
  logic [2:0]  sts_reg;
  logic [2:0]  sts_next;
  logic [2:0]  ien_reg;
  logic [2:0]  sts_set;
  logic [2:0]  sts_clr;
  lcd_state_t  state_reg;
  logic [11:0] cnt_reg;
  logic [31:0] gap_reg;
  logic        credit_reg;
  logic        edge_seen;
  logic        carrier_lvl;
  logic        az_active;
  logic        az_end;
  logic        gap_expired;
  logic [11:0] target;
  logic [11:0] cnt_step;
  logic        reached;
  logic        found_ok;
  logic        wr_fire;
  logic        access;
  logic [31:0] rd_mux;
  logic        addr_ok;

  wire carrier_found_flag       = sts_reg[STS_FOUND_BIT];
  wire carrier_found_irq_enable = ien_reg[STS_FOUND_BIT];

  // ----------------------------------------------------------------
  // Pin synchroniser and auto-zero
  // ----------------------------------------------------------------
  lcd_pin_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .pin_in     (carrier_in),
    .level_out  (carrier_lvl),
    .rise_out   (edge_seen)
  );

  lcd_autozero #(.PERIOD_CYC(AZ_PERIOD)) u_az (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .enable_in  (rx_enable_reg),
    .active_out (az_active),
    .end_out    (az_end)
  );

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  assign access  = psel_in & penable_in;
  assign wr_fire = access & pready_out & pwrite_in;
  assign addr_ok = (paddr_in == OFS_CTRL3) | (paddr_in == OFS_CTRL4) | (paddr_in == OFS_LIMIT) |
                   (paddr_in == OFS_STATE) | (paddr_in == OFS_STS) | (paddr_in == OFS_CLR) |
                   (paddr_in == OFS_IEN);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      OFS_CTRL3: rd_mux = {24'h00_0000, detector_mode_select, 1'b0, sync_sel_reg, carrier_qualify_time};
      OFS_CTRL4: rd_mux = {30'h0000_0000, rx_enable_reg, digital_decode_enable};
      OFS_LIMIT: rd_mux = {20'h0_0000, carrier_count_limit};
      OFS_STATE: rd_mux = {16'h0000, cnt_reg, az_active, carrier_lvl, decode_chain_on_out, carrier_found_flag};
      OFS_STS:   rd_mux = {29'h0000_0000, sts_reg};
      OFS_IEN:   rd_mux = {29'h0000_0000, ien_reg};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (access && !pready_out) begin
      pready_out  <= 1'b1;
      prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= ~addr_ok;
    end else begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_sel_reg          <= SYNC_RST;
      carrier_qualify_time  <= QTIME_RST;
      detector_mode_select  <= MODE_RST;
      digital_decode_enable <= DIGITAL_DECODE_ENABLE_RST;
      rx_enable_reg         <= RXEN_RST;
      carrier_count_limit   <= LIMIT_RST;
      ien_reg               <= 3'h0;
    end else if (wr_fire) begin
      case (paddr_in)
        OFS_CTRL3: begin
          // code 00 stored but reserved for factory test
          sync_sel_reg         <= pwdata_in[CTRL3_SYNC_LSB +: 2];
          carrier_qualify_time <= pwdata_in[CTRL3_QTIME_LSB +: 4];
          detector_mode_select <= pwdata_in[CTRL3_MODE_BIT];
        end
        OFS_CTRL4: begin
          digital_decode_enable <= pwdata_in[CTRL4_DIGITAL_DECODE_ENABLE_BIT];
          rx_enable_reg         <= pwdata_in[CTRL4_RXEN_BIT];
        end
        OFS_LIMIT: carrier_count_limit <= pwdata_in[11:0];
        OFS_IEN:   ien_reg <= pwdata_in[2:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_select_out <= SYNC_RST;
    end else begin
      sync_select_out <= sync_sel_reg;
    end
  end

  // ----------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------
  // code table
  // data mode fixed at 8 for 0xxx
  assign target = qual_target(carrier_qualify_time, detector_mode_select);
  // credit the auto-zero periods on the first edge after it
  assign cnt_step = credit_reg ? (cnt_reg + AZ_PERIODS + 12'h001) : (cnt_reg + 12'h001);
  // carrier mode also waits for the count limit
  assign reached = (cnt_step >= target) &&
                   (!detector_mode_select || (cnt_step >= carrier_count_limit));
  assign gap_expired = (gap_reg >= 32'(GAP_CYC - 1));

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 12'h000;
      gap_reg    <= 32'h0000_0000;
      credit_reg <= 1'b0;
    end else if (!rx_enable_reg) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 12'h000;
      gap_reg    <= 32'h0000_0000;
      credit_reg <= 1'b0;
    end else if (az_active) begin
      gap_reg    <= 32'h0000_0000;
      credit_reg <= (state_reg == ST_QUALIFY);
    end else begin
      gap_reg <= edge_seen ? 32'h0000_0000 : (gap_expired ? gap_reg : gap_reg + 32'h0000_0001);
      case (state_reg)
        ST_IDLE: begin
          cnt_reg    <= 12'h000;
          credit_reg <= 1'b0;
          if (edge_seen) begin
            cnt_reg   <= 12'h001;
            state_reg <= ST_QUALIFY;
          end
        end
        ST_QUALIFY: begin
          if (edge_seen) begin
            cnt_reg    <= cnt_step;
            credit_reg <= 1'b0;
            if (reached) begin
              state_reg <= detector_mode_select ? ST_HELD : ST_FRAME;
            end
          end else if (gap_expired) begin
            cnt_reg    <= 12'h000;
            credit_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        ST_FRAME, ST_HELD: begin
          // field ignored until the carrier drops
          if (gap_expired) begin
            cnt_reg   <= 12'h000;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      decode_chain_on_out <= 1'b0;
      autozero_out        <= 1'b0;
    end else begin
      decode_chain_on_out <= (state_reg == ST_FRAME);
      autozero_out        <= az_active;
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  assign found_ok = rx_enable_reg && !az_active && (state_reg == ST_QUALIFY) && edge_seen && reached;

  always_comb begin
    sts_set = 3'h0;
    sts_clr = 3'h0;
    sts_set[STS_FOUND_BIT] = found_ok;
    sts_set[STS_CHAIN_BIT] = found_ok && !detector_mode_select;
    sts_set[STS_LOST_BIT]  = rx_enable_reg && !az_active && (state_reg != ST_IDLE) && gap_expired &&
                             !edge_seen;
    if (wr_fire && (paddr_in == OFS_CLR)) begin
      sts_clr = pwdata_in[2:0];
    end
    // Set wins over a clear in the same cycle
    sts_next = (sts_reg & ~sts_clr) | sts_set;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sts_reg <= 3'h0;
    end else begin
      sts_reg <= sts_next;
    end
  end

  // found flag with enable raises interrupt
  // suppressed in data mode while decoding is on
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (carrier_found_flag && carrier_found_irq_enable &&
                  (detector_mode_select || !digital_decode_enable)) ||
                 |(sts_reg[2:1] & ien_reg[2:1]);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sync_reset: assert property (@(posedge ref_clk_in) $rose(resetn_in) |-> sync_sel_reg == 2'h1)
    else $error("sync field not 01 after reset");

  chk_qtime_reset: assert property (@(posedge ref_clk_in) $rose(resetn_in) |-> carrier_qualify_time == 4'h0)
    else $error("qualify time not cleared by reset");

  chk_found_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    found_ok |=> carrier_found_flag)
    else $error("found flag missed qualification");

  chk_irq_follow: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (carrier_found_flag && carrier_found_irq_enable && detector_mode_select) |=> irq_out)
    else $error("wake-up interrupt not raised");

  chk_irq_datamode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!detector_mode_select && digital_decode_enable && ((sts_reg[2:1] & ien_reg[2:1]) == 2'b00)) |=> !irq_out)
    else $error("found interrupt in data mode");

  chk_chain_wait: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(decode_chain_on_out) |-> $past(state_reg, 2) == ST_QUALIFY && $past(cnt_reg) >= 12'h008)
    else $error("decode chain powered before qualification");

  chk_frame_hold: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (state_reg == ST_FRAME && rx_enable_reg && !gap_expired) |=> state_reg == ST_FRAME)
    else $error("frame dropped while carrier present");

  chk_az_hold: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (az_active && rx_enable_reg) |=> cnt_reg == $past(cnt_reg))
    else $error("count moved during auto-zero");

  chk_az_credit: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (rx_enable_reg && !az_active && state_reg == ST_QUALIFY && edge_seen && credit_reg)
    |=> cnt_reg == $past(cnt_reg) + 12'h009)
    else $error("auto-zero periods not credited");

  chk_lost_restart: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (rx_enable_reg && !az_active && state_reg == ST_QUALIFY && gap_expired && !edge_seen)
    |=> cnt_reg == 12'h000 && state_reg == ST_IDLE)
    else $error("count not restarted on carrier loss");

  chk_az_period: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(az_active) |-> !az_active [*8])
    else $error("auto-zero window too close");

endmodule

// file: core/lcd_pkg.sv
// Constants, register map and count tables for the carrier qualification block.
// Assumes one 50 MHz clock and an APB register port with 32-bit data.
package lcd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 50_000_000;
  localparam int CLK_MHZ          = CLK_HZ / 1_000_000;
  localparam int CARRIER_KHZ      = 125;
  localparam int AZ_PERIOD_US     = 1000;
  localparam int AZ_PERIOD_CYC    = AZ_PERIOD_US * CLK_MHZ;
  localparam int AZ_LEN_US        = 64;
  localparam int AZ_LEN_CYC       = AZ_LEN_US * CLK_MHZ;
  // Carrier counts as gone after two silent periods
  localparam int GAP_US           = 16;
  localparam int GAP_CYC          = GAP_US * CLK_MHZ;
  localparam logic [11:0] AZ_PERIODS = 12'(AZ_LEN_US * CARRIER_KHZ / 1000);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL3  = 8'h00;
  localparam logic [7:0] OFS_CTRL4  = 8'h04;
  localparam logic [7:0] OFS_LIMIT  = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;
  localparam logic [7:0] OFS_STS    = 8'h10;
  localparam logic [7:0] OFS_CLR    = 8'h14;
  localparam logic [7:0] OFS_IEN    = 8'h18;

  localparam int CTRL3_QTIME_LSB    = 0;
  localparam int CTRL3_SYNC_LSB     = 4;
  localparam int CTRL3_MODE_BIT     = 7;
  localparam int CTRL4_DIGITAL_DECODE_ENABLE_BIT    = 0;
  localparam int CTRL4_RXEN_BIT     = 1;
  localparam int STS_FOUND_BIT      = 0;
  localparam int STS_CHAIN_BIT      = 1;
  localparam int STS_LOST_BIT       = 2;

  localparam logic [1:0]  SYNC_RST  = 2'h1;
  localparam logic [3:0]  QTIME_RST = 4'h0;
  localparam logic        MODE_RST  = 1'b0;
  localparam logic        DIGITAL_DECODE_ENABLE_RST = 1'b1;
  localparam logic        RXEN_RST  = 1'b0;
  localparam logic [11:0] LIMIT_RST = 12'h008;

  // ----------------------------------------------------------------
  // Qualification count in carrier periods
  // ----------------------------------------------------------------
  function automatic logic [11:0] qual_target(input logic [3:0] code, input logic carrier_mode);
    logic [11:0] cm;
    logic [11:0] dm;
    case (code)
      4'h0: cm = 12'h008;
      4'h1: cm = 12'h010;
      4'h2: cm = 12'h080;
      4'h3: cm = 12'h100;
      4'h4: cm = 12'h200;
      4'h5: cm = 12'h200;
      4'h6: cm = 12'h200;
      4'h7: cm = 12'h400;
      4'h8: cm = 12'h008;
      4'h9: cm = 12'h010;
      4'hA: cm = 12'h020;
      4'hB: cm = 12'h040;
      4'hC: cm = 12'h080;
      4'hD: cm = 12'h100;
      4'hE: cm = 12'h200;
      default: cm = 12'h400;
    endcase
    dm = (code[3:2] == 2'b11) ? cm : 12'h008;
    return carrier_mode ? cm : dm;
  endfunction

endpackage

// file: core/lcd_pin_sync.sv
// Two-flop synchroniser for the detector pin with a rising-edge pulse.
// Assumes the pin is asynchronous to the clock.
`timescale 1ns/1ps
module lcd_pin_sync
  import lcd_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic resetn_in,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_reg  <= pin_in;
      sync_reg  <= meta_reg;
      level_out <= sync_reg;
    end
  end

  // Edge taken from the second and third stages only
  assign rise_out = sync_reg & ~level_out;

endmodule

// file: core/lcd_autozero.sv
// Periodic auto-zero window generator: a 64 us window every 1 ms.
// Assumes the enable comes from logic on the same clock.
`timescale 1ns/1ps
module lcd_autozero
  import lcd_pkg::*;
#(
  parameter int PERIOD_CYC = AZ_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic resetn_in,
  // Control and window
  input  wire logic enable_in,
  output logic      active_out,
  output logic      end_out
);

  logic [31:0] per_reg;
  logic [31:0] len_reg;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      per_reg    <= 32'h0000_0000;
      len_reg    <= 32'h0000_0000;
      active_out <= 1'b0;
      end_out    <= 1'b0;
    end else if (!enable_in) begin
      per_reg    <= 32'h0000_0000;
      len_reg    <= 32'h0000_0000;
      active_out <= 1'b0;
      end_out    <= 1'b0;
    end else begin
      end_out <= 1'b0;
      per_reg <= (per_reg == 32'(PERIOD_CYC - 1)) ? 32'h0000_0000 : per_reg + 32'h0000_0001;
      if (per_reg == 32'(PERIOD_CYC - 1)) begin
        active_out <= 1'b1;
        len_reg    <= 32'h0000_0000;
      end else if (active_out) begin
        len_reg <= len_reg + 32'h0000_0001;
        if (len_reg == 32'(AZ_LEN_CYC - 1)) begin
          active_out <= 1'b0;
          end_out    <= 1'b1;
        end
      end
    end
  end

endmodule

// file: tb/lcd_lf_tx_model.sv
// Far-side model: a low-frequency transmitter sending whole carrier periods.
// Assumes the bench calls send from its main process; idle line is low.
`timescale 1ns/1ps
module lcd_lf_tx_model #(
  parameter int HALF_CYC = 200
)
(
  // Clock
  input  wire logic ref_clk_in,
  // Carrier towards the detector
  output logic      carrier_out
);
  // No carrier between bursts
  initial carrier_out = 1'b0;

  // bursts stand in for the preamble carrier
  // one rising edge per 8 us period
  task automatic send(input int n);
    repeat (n) begin
      repeat (HALF_CYC) @(posedge ref_clk_in);
      carrier_out <= 1'b1;
      repeat (HALF_CYC) @(posedge ref_clk_in);
      carrier_out <= 1'b0;
    end
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the carrier qualification block.
// Assumes a shortened auto-zero period so the run stays short.
`timescale 1ns/1ps
module tb_top
  import lcd_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int AZP = 8000;
  logic        ref_clk_in;
  logic        resetn_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        carrier;
  logic        chain;
  logic [1:0]  sync;
  logic        az;
  logic        irq;
  int          miscompares;
  int          comparisons;

  lcd_top #(.AZ_PERIOD(AZP)) lcd_top_i (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .carrier_in(carrier),
    .decode_chain_on_out(chain), .sync_select_out(sync), .autozero_out(az), .irq_out(irq)
  );
  lcd_lf_tx_model lcd_lf_tx_model_i (.ref_clk_in(ref_clk_in), .carrier_out(carrier));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'(pready), 32'h0000_0001);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q & m, exp);
  endtask

  // Bursts start just after an auto-zero so one of up to 8 periods lands clear of the next
  task automatic after_az();
    int n;
    n = 0;
    while (az !== 1'b1 && n < 20000) begin
      @(posedge ref_clk_in);
      n++;
    end
    while (az !== 1'b0 && n < 20000) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    chk(32'(sync), 32'h0000_0001);
    rd(OFS_CTRL3, 32'hFFFF_FFFF, 32'h0000_0010);
    rd(OFS_CTRL4, 32'hFFFF_FFFF, 32'h0000_0001);
    rd(OFS_LIMIT, 32'hFFFF_FFFF, 32'h0000_0008);
    apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
  endtask

  task automatic t_sync();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL3, 32'(c) << 4);
      repeat (2) @(posedge ref_clk_in);
      chk(32'(sync), 32'(c));
      rd(OFS_CTRL3, 32'hFFFF_FFFF, 32'(c) << 4);
    end
    // Upper bits of the limit word are dropped on write
    wr(OFS_LIMIT, 32'hFFFF_FABC);
    rd(OFS_LIMIT, 32'hFFFF_FFFF, 32'h0000_0ABC);
    wr(OFS_LIMIT, 32'h0000_0008);
    rd(OFS_LIMIT, 32'hFFFF_FFFF, 32'h0000_0008);
  endtask

  task automatic t_carrier();
    wr(OFS_CTRL3, 32'h0000_0090);
    wr(OFS_CTRL4, 32'h0000_0003);
    after_az();
    lcd_lf_tx_model_i.send(7);
    repeat (1000) @(posedge ref_clk_in);
    rd(OFS_STS, 32'h0000_0001, 32'h0000_0000);
    after_az();
    lcd_lf_tx_model_i.send(7);
    repeat (1000) @(posedge ref_clk_in);
    rd(OFS_STS, 32'h0000_0001, 32'h0000_0000);
    after_az();
    lcd_lf_tx_model_i.send(8);
    rd(OFS_STS, 32'h0000_0001, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IEN, 32'h0000_0001);
    repeat (3) @(posedge ref_clk_in);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_CLR, 32'h0000_0007);
    repeat (3) @(posedge ref_clk_in);
    chk(32'(irq), 32'h0000_0000);
  endtask

  task automatic t_az();
    int n;
    n = 0;
    while (az !== 1'b1 && n < 9000) begin
      @(posedge ref_clk_in);
      n++;
    end
    n = 0;
    while (az === 1'b1 && n < 9000) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(32'(n), 32'(AZ_LEN_CYC));
    n = 0;
    while (az !== 1'b1 && n < 9000) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(32'(n), 32'(AZP - AZ_LEN_CYC));
  endtask

  task automatic t_data();
    wr(OFS_CTRL3, 32'h0000_0011);
    after_az();
    lcd_lf_tx_model_i.send(7);
    chk(32'(chain), 32'h0000_0000);
    lcd_lf_tx_model_i.send(1);
    chk(32'(chain), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    rd(OFS_STS, 32'h0000_0003, 32'h0000_0003);
    wr(OFS_CTRL4, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_in);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_CTRL4, 32'h0000_0003);
    wr(OFS_CLR, 32'h0000_0007);
    // Carrier stops: the lost event must raise its own interrupt
    wr(OFS_IEN, 32'h0000_0004);
    repeat (1000) @(posedge ref_clk_in);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_CLR, 32'h0000_0007);
    repeat (3) @(posedge ref_clk_in);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // Long window spans several auto-zeros; without bridging it never qualifies
  task automatic t_long();
    wr(OFS_CTRL3, 32'h0000_001C);
    // First edge must fall outside an auto-zero, or up to 8 periods go uncredited
    after_az();
    lcd_lf_tx_model_i.send(110);
    chk(32'(chain), 32'h0000_0000);
    lcd_lf_tx_model_i.send(20);
    chk(32'(chain), 32'h0000_0001);
  endtask

  // ----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    resetn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_sync();
    t_carrier();
    t_az();
    t_data();
    t_long();
    stop_test();
  end

  initial begin
    repeat (160000) @(posedge ref_clk_in);
    miscompares++;
    stop_test();
  end
endmodule
